// file: core/eifes_core.sv
// External interrupt filter, edge select and address trap latch.
// Assumes pins synchronous-sampled on sys_clk and an fs tick from the clock unit.
`timescale 1ns/1ps

module eifes_core (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        low_speed_mode,
  input  wire logic        low_freq_tick,
  input  wire logic [4:0]  ext_irq_pins,
  input  wire logic        fetch_in_trap_area,
  input  wire logic [8:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [4:0]  irq_request,
  output logic             address_trap_irq,
  output logic             trap_reset_out,
  output logic             port1_bit0,
  output logic             pin_function_select
);

  typedef struct packed {
    logic [4:0]                      sync1;
    logic [4:0]                      sync2;
    logic [4:0]                      filt;
    logic [4:0][eifes_pkg::CNT_W-1:0] cnt;
    logic [1:0]                      init;
    logic [1:0]                      armed;
    logic [7:0]                      ctrl;
    logic [5:0]                      enable;
    logic [5:0]                      latch;
    logic                            trap_mode;
    logic                            trap_reset;
    logic                            port_bit;
    logic                            ack;
    logic [31:0]                     rdata;
  } eifes_state_type;

  localparam eifes_state_type RESET_STATE = '{
    sync1: 5'h00, sync2: 5'h00, filt: 5'h00, cnt: '0, init: 2'h0,
    armed: 2'h0, ctrl: eifes_pkg::CTRL_RESET, enable: 6'h00, latch: 6'h00,
    trap_mode: 1'b0, trap_reset: 1'b0, port_bit: 1'b0, ack: 1'b0,
    rdata: 32'h0000_0000};

  eifes_state_type s;
  eifes_state_type next_s;

  logic                       req;
  logic                       commit_wr;
  logic [6:0]                 idx;
  logic                       tick;
  logic                       init_done;
  logic [4:0]                 rise;
  logic [4:0]                 fall;
  logic [5:0]                 set_bits;
  logic [5:0]                 clr_bits;
  logic [1:0]                 trig_sel [2];
  logic [eifes_pkg::CNT_W-1:0] thr;
  logic [eifes_pkg::CNT_W-1:0] cnt_inc;

  // Bus decode; the answer comes one cycle after the request is seen.
  assign req       = avs_read | avs_write;
  assign idx       = avs_address[8:2];
  assign commit_wr = avs_write & s.ack & clk_en & avs_byteenable[0];
  assign avs_waitrequest = req & ~(s.ack & clk_en);
  assign avs_readdata    = s.rdata;

  // Requests are gated by the master and per-pin flags; trap is never gated.
  assign irq_request = s.latch[4:0] & s.enable[5:1]
                       & {5{s.enable[eifes_pkg::EN_MASTER_BIT]}};
  assign address_trap_irq    = s.latch[eifes_pkg::TRAP_LATCH_BIT];
  assign trap_reset_out      = s.trap_reset;
  assign port1_bit0          = s.port_bit;
  assign pin_function_select = s.ctrl[eifes_pkg::CTRL_PINFN_BIT];

  // Next-state logic for the whole block.
  always_comb begin
    next_s    = s;
    tick      = low_speed_mode ? low_freq_tick : 1'b1;
    init_done = (s.init == eifes_pkg::INIT_CYCLES);
    rise      = 5'h00;
    fall      = 5'h00;
    set_bits  = 6'h00;
    clr_bits  = 6'h00;
    thr       = eifes_pkg::THR_ZF;
    cnt_inc   = '0;
    trig_sel[0] = s.ctrl[eifes_pkg::CTRL_T3_LSB +: 2];
    trig_sel[1] = s.ctrl[eifes_pkg::CTRL_T4_LSB +: 2];
    if (clk_en) begin
      // Two-stage synchroniser; only the second stage feeds the filters.
      next_s.sync1 = ext_irq_pins;
      next_s.sync2 = s.sync1;
      next_s.port_bit = s.sync2[eifes_pkg::PIN_ZERO];
      if (!init_done) begin
        // Filters take the settled pin level with no edge, so a high pin at release is no event.
        next_s.init = s.init + 2'h1;
        next_s.filt = s.sync2;
        next_s.cnt  = '0;
      end else begin
        for (int i = 0; i < 5; i++) begin
          if (low_speed_mode) begin
            thr = eifes_pkg::THR_FS;
          end else if (i == eifes_pkg::PIN_ONE) begin
            thr = s.ctrl[eifes_pkg::CTRL_FILT_BIT] ? eifes_pkg::THR_OS
                                                   : eifes_pkg::THR_OL;
          end else if (i == eifes_pkg::PIN_THREE || i == eifes_pkg::PIN_FOUR) begin
            thr = eifes_pkg::THR_TF;
          end else begin
            thr = eifes_pkg::THR_ZF;
          end
          cnt_inc = s.cnt[i] + 1'b1;
          // A level must differ for thr counted samples before it is accepted.
          if (s.sync2[i] == s.filt[i]) begin
            next_s.cnt[i] = '0;
          end else if (tick) begin
            if (cnt_inc >= thr) begin
              next_s.filt[i] = s.sync2[i];
              next_s.cnt[i]  = '0;
            end else begin
              next_s.cnt[i] = cnt_inc;
            end
          end
        end
        rise = next_s.filt & ~s.filt;
        fall = s.filt & ~next_s.filt;
      end

      // Event qualification per pin.
      set_bits[0] = fall[eifes_pkg::PIN_ZERO]
                    & s.ctrl[eifes_pkg::CTRL_PINFN_BIT];
      set_bits[1] = s.ctrl[eifes_pkg::CTRL_E1_BIT] ? fall[eifes_pkg::PIN_ONE]
                                                   : rise[eifes_pkg::PIN_ONE];
      for (int j = 0; j < 2; j++) begin
        next_s.armed[j] = s.armed[j] | rise[eifes_pkg::PIN_THREE + j];
        case (trig_sel[j])
          eifes_pkg::TRIG_RISE: set_bits[2 + j] = rise[eifes_pkg::PIN_THREE + j];
          eifes_pkg::TRIG_FALL: set_bits[2 + j] = fall[eifes_pkg::PIN_THREE + j];
          eifes_pkg::TRIG_BOTH: set_bits[2 + j] = rise[eifes_pkg::PIN_THREE + j]
                                                 | fall[eifes_pkg::PIN_THREE + j];
          eifes_pkg::TRIG_LEVEL: set_bits[2 + j] = next_s.filt[eifes_pkg::PIN_THREE + j]
                                                  & next_s.armed[j];
          default: set_bits[2 + j] = 1'b0;
        endcase
      end
      set_bits[4] = fall[eifes_pkg::PIN_FIVE];
      // Latches follow the pin whatever its direction, except pin zero, which latches only with the pin function bit set; the enable flags mask spurious ones.
      set_bits[eifes_pkg::TRAP_LATCH_BIT] = fetch_in_trap_area & s.trap_mode;
      next_s.trap_reset = fetch_in_trap_area & ~s.trap_mode;

      // Register reads are captured while the request waits.
      next_s.ack = req & ~s.ack;
      if (req && !s.ack) begin
        case (idx)
          eifes_pkg::IDX_EXT_CTRL: next_s.rdata = {24'h000000, s.ctrl & eifes_pkg::CTRL_RD_MASK};
          eifes_pkg::IDX_ENABLE:   next_s.rdata = {26'h0000000, s.enable};
          eifes_pkg::IDX_LATCH:    next_s.rdata = {19'h00000, s.filt, 2'h0, s.latch};
          eifes_pkg::IDX_TRAP:     next_s.rdata = {31'h00000000, s.trap_mode};
          default:                 next_s.rdata = 32'h0000_0000;
        endcase
      end

      // Writes take effect at the edge where waitrequest is low.
      if (commit_wr) begin
        case (idx)
          eifes_pkg::IDX_EXT_CTRL: next_s.ctrl      = avs_writedata[7:0];
          eifes_pkg::IDX_ENABLE:   next_s.enable    = avs_writedata[5:0];
          eifes_pkg::IDX_LATCH:    clr_bits         = avs_writedata[5:0];
          eifes_pkg::IDX_TRAP:     next_s.trap_mode = avs_writedata[0];
          default:                 clr_bits         = 6'h00;
        endcase
      end
      // A new event beats a clear in the same cycle.
      next_s.latch = (s.latch & ~clr_bits) | set_bits;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

endmodule

// file: core/eifes_pkg.sv
// Constants for the external interrupt filter and edge select block.
// Assumes a single fc clock; low-speed timing comes from an fs tick input.
package eifes_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [6:0] IDX_EXT_CTRL = 7'h37;
  localparam logic [6:0] IDX_ENABLE   = 7'h40;
  localparam logic [6:0] IDX_LATCH    = 7'h41;
  localparam logic [6:0] IDX_TRAP     = 7'h42;
  // Control register fields and reset value.
  localparam int unsigned CTRL_FILT_BIT  = 7;
  localparam int unsigned CTRL_PINFN_BIT = 6;
  localparam int unsigned CTRL_T3_LSB    = 4;
  localparam int unsigned CTRL_T4_LSB    = 2;
  localparam int unsigned CTRL_E1_BIT    = 1;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  CTRL_RD_MASK   = 8'hfe;
  // Enable register: bit 0 master, bits 1..5 per-pin flags.
  localparam int unsigned EN_MASTER_BIT = 0;
  localparam int unsigned TRAP_LATCH_BIT = 5;
  localparam int unsigned FILT_RD_LSB    = 8;
  // Pin positions inside the pin vector.
  localparam int unsigned PIN_ZERO  = 0;
  localparam int unsigned PIN_ONE   = 1;
  localparam int unsigned PIN_THREE = 2;
  localparam int unsigned PIN_FOUR  = 3;
  localparam int unsigned PIN_FIVE  = 4;
  // Trigger select codes for pins three and four.
  localparam logic [1:0] TRIG_RISE  = 2'h0;
  localparam logic [1:0] TRIG_FALL  = 2'h1;
  localparam logic [1:0] TRIG_BOTH  = 2'h2;
  localparam logic [1:0] TRIG_LEVEL = 2'h3;
  // Clock rate; the system clock is the high-frequency clock.
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned FC_HZ  = 25000000;
  // Reject and accept times in fc periods.
  localparam int unsigned ZF_REJ_FC  = 2;
  localparam int unsigned ZF_ACC_FC  = 7;
  localparam int unsigned OL_REJ_FC  = 63;
  localparam int unsigned OL_ACC_FC  = 193;
  localparam int unsigned OS_REJ_FC  = 15;
  localparam int unsigned OS_ACC_FC  = 49;
  localparam int unsigned TF_REJ_FC  = 7;
  localparam int unsigned TF_ACC_FC  = 25;
  localparam int unsigned NC_SWITCH_FC = 64;
  // Low-speed times in half fs periods (1/fs and 3.5/fs).
  localparam int unsigned FS_REJ_HALF = 2;
  localparam int unsigned FS_ACC_HALF = 7;
  // Filter thresholds: midway between reject and accept times.
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] THR_ZF =
    CNT_W'((ZF_REJ_FC + ZF_ACC_FC) * (CLK_HZ / FC_HZ) / 2);
  localparam logic [CNT_W-1:0] THR_OL =
    CNT_W'((OL_REJ_FC + OL_ACC_FC) * (CLK_HZ / FC_HZ) / 2);
  localparam logic [CNT_W-1:0] THR_OS =
    CNT_W'((OS_REJ_FC + OS_ACC_FC) * (CLK_HZ / FC_HZ) / 2);
  localparam logic [CNT_W-1:0] THR_TF =
    CNT_W'((TF_REJ_FC + TF_ACC_FC) * (CLK_HZ / FC_HZ) / 2);
  localparam logic [CNT_W-1:0] THR_FS = CNT_W'((FS_REJ_HALF + FS_ACC_HALF) / 4);
  // Cycles after reset during which the filters adopt the pin level silently.
  localparam logic [1:0] INIT_CYCLES = 2'h3;
endpackage

// file: testbench/eifes_pin_src.sv
// Model of the signal sources on the five external interrupt pins.
// Assumes the bench requests each pulse with a one-cycle go strobe.
`timescale 1ns/1ps
module eifes_pin_src (
  input  wire logic        sys_clk,
  input  wire logic [4:0]  idle_lvl,
  input  wire logic [4:0]  pulse_sel,
  input  wire logic [15:0] pulse_len,
  input  wire logic        go,
  output logic      [4:0]  pins
);
  logic [15:0] left = 16'h0;
  // Counts down the cycles during which the chosen pins stay inverted.
  always @(posedge sys_clk) begin
    if (go) begin
      left <= pulse_len;
    end else if (left != 16'h0) begin
      left <= left - 16'h1;
    end
  end
  // Pins change only just after clock edges, so pulse widths are exact.
  assign pins = idle_lvl ^ ((left != 16'h0) ? pulse_sel : 5'h0);
endmodule

// file: testbench/eifes_sva.sv
// Checker for the external interrupt filter core, watching its ports only.
// Assumes one clock, sys_clk, and the synchronous active-high sys_rst.
`timescale 1ns/1ps
module eifes_sva (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic [4:0]  ext_irq_pins,
  input wire logic        fetch_in_trap_area,
  input wire logic [8:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic [4:0]  irq_request,
  input wire logic        address_trap_irq,
  input wire logic        trap_reset_out,
  input wire logic        port1_bit0,
  input wire logic        pin_function_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] since_rst;
  logic       ctrl_wr;
  logic       trap_clr;
  // Counts the cycles since reset release, stopping at seven.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      since_rst <= 3'h0;
    end else if (since_rst != 3'h7) begin
      since_rst <= since_rst + 3'h1;
    end
  end
  // Accepted writes to the control register and trap clears.
  assign ctrl_wr  = avs_write && !avs_waitrequest && avs_address == 9'h0dc && avs_byteenable[0];
  assign trap_clr = avs_write && !avs_waitrequest && avs_address == 9'h104 && avs_writedata[5];
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest && clk_en;
  endsequence
  sequence s_fetch;
    fetch_in_trap_area;
  endsequence
  a_wait_one: assert property (s_req_wait |=> !avs_waitrequest || !clk_en)
    else $error("bus wait lasted more than one cycle");
  a_trap_cause: assert property (trap_reset_out |-> $past(fetch_in_trap_area))
    else $error("trap reset without a trapped fetch");
  a_trap_effect: assert property (s_fetch |=> trap_reset_out || address_trap_irq)
    else $error("trapped fetch had no effect");
  a_trap_hold: assert property (address_trap_irq && !trap_clr |=> address_trap_irq)
    else $error("trap request dropped without a clear");
  a_zero_gate: assert property (irq_request[0] |-> pin_function_select)
    else $error("pin zero request while pin is a port");
  a_ctrl_mirror: assert property (ctrl_wr |=> pin_function_select == $past(avs_writedata[6]))
    else $error("pin function select does not follow the write");
  a_port_follow: assert property (since_rst == 3'h7 |-> port1_bit0 == $past(ext_irq_pins[0], 3))
    else $error("port read value does not follow pin zero");
  a_reset_quiet: assert property (since_rst == 3'h0 |-> irq_request == 5'h0 && !address_trap_irq
    && !trap_reset_out && !pin_function_select)
    else $error("outputs not cleared after reset");
endmodule
bind eifes_core eifes_sva eifes_sva_i (.sys_clk, .sys_rst, .clk_en, .ext_irq_pins,
  .fetch_in_trap_area, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .irq_request, .address_trap_irq, .trap_reset_out, .port1_bit0,
  .pin_function_select);

// file: testbench/ext_irq_filter_edge_select_tb_top.sv
// Self-checking bench for the external interrupt filter and edge select core.
// Assumes the core under core/ and the pin source model beside this file.
`timescale 1ns/1ps
module ext_irq_filter_edge_select_tb_top;
  logic        sys_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        clk_en = 1'h1;
  logic        low_speed_mode = 1'h0;
  logic        low_freq_tick = 1'h0;
  logic [2:0]  tick_div = 3'h0;
  logic [4:0]  ext_irq_pins;
  logic        fetch_in_trap_area = 1'h0;
  logic [8:0]  avs_address = 9'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [4:0]  irq_request;
  logic        address_trap_irq;
  logic        trap_reset_out;
  logic        port1_bit0;
  logic        pin_function_select;
  logic [4:0]  idle_lvl = 5'h15;
  logic [4:0]  pulse_sel = 5'h0;
  logic [15:0] pulse_len = 16'h0;
  logic        go = 1'h0;
  int          n_errors = 0;
  int          tests_run = 0;
  // Clock of 40 ns period.
  always #20 sys_clk = ~sys_clk;
  // Low-frequency tick once every eight clock cycles.
  always @(posedge sys_clk) begin
    tick_div <= tick_div + 3'h1;
    low_freq_tick <= (tick_div == 3'h7);
  end
  eifes_core eifes_core_i (.sys_clk, .sys_rst, .clk_en, .low_speed_mode, .low_freq_tick,
    .ext_irq_pins, .fetch_in_trap_area, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_request, .address_trap_irq,
    .trap_reset_out, .port1_bit0, .pin_function_select);
  eifes_pin_src eifes_pin_src_i (.sys_clk, .idle_lvl, .pulse_sel, .pulse_len, .go,
    .pins(ext_irq_pins));
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    // The request stands until the rising edge at which waitrequest is sampled low.
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task chk(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    cmp(q & m, e);
  endtask
  task flt(input int p, input logic [7:0] c, input int n, input logic e);
    // The control word is rewritten with c, then all six latches are cleared before the pulse.
    wr(9'h0dc, {24'h0, c});
    wr(9'h104, 32'h3f);
    @(posedge sys_clk);
    pulse_sel <= 5'(1 << p);
    pulse_len <= 16'(n);
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
    cyc(n + 40);
    chk(9'h104, 32'(1 << p), e ? 32'(1 << p) : 32'h0);
  endtask
  task edg(input logic [4:0] m, input logic [7:0] c, input logic r, input logic f);
    wr(9'h0dc, {24'h0, c});
    cyc(60);
    wr(9'h104, 32'h3f);
    idle_lvl <= idle_lvl | m;
    cyc(60);
    chk(9'h104, {27'h0, m}, r ? {27'h0, m} : 32'h0);
    wr(9'h104, 32'h3f);
    idle_lvl <= idle_lvl & ~m;
    cyc(60);
    chk(9'h104, {27'h0, m}, f ? {27'h0, m} : 32'h0);
  endtask
  task trap(input logic m);
    wr(9'h108, {31'h0, m});
    fetch_in_trap_area <= 1'h1;
    @(posedge sys_clk);
    fetch_in_trap_area <= 1'h0;
    @(negedge sys_clk);
    cmp({30'h0, address_trap_irq, trap_reset_out}, m ? 32'h2 : 32'h1);
  endtask
  task tally_and_finish;
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog that ends a hung run.
  initial begin
    cyc(60000);
    n_errors++;
    tally_and_finish;
  end
  // Main sequence of scenarios.
  initial begin
    cyc(12);
    sys_rst <= 1'h0;
    chk(9'h0dc, 32'hff, 32'h0);
    wr(9'h0dc, 32'h30);
    cyc(40);
    chk(9'h104, 32'h4, 32'h0);
    idle_lvl <= 5'h11;
    cyc(40);
    idle_lvl <= 5'h15;
    cyc(40);
    chk(9'h104, 32'h4, 32'h4);
    idle_lvl <= 5'h11;
    wr(9'h0dc, 32'hff);
    chk(9'h0dc, 32'hff, 32'hfe);
    chk(9'h1fc, 32'hffffffff, 32'h0);
    flt(4, 8'h00, 1, 1'h0);
    flt(4, 8'h00, 7, 1'h1);
    flt(0, 8'h00, 7, 1'h0);
    flt(0, 8'h40, 7, 1'h1);
    wr(9'h100, 32'h3);
    @(negedge sys_clk);
    cmp({27'h0, irq_request}, 32'h1);
    wr(9'h100, 32'h2);
    @(negedge sys_clk);
    cmp({27'h0, irq_request}, 32'h0);
    flt(2, 8'h00, 6, 1'h0);
    flt(2, 8'h00, 25, 1'h1);
    flt(1, 8'h00, 62, 1'h0);
    flt(1, 8'h00, 193, 1'h1);
    flt(1, 8'h80, 14, 1'h0);
    flt(1, 8'h80, 62, 1'h1);
    edg(5'h02, 8'h80, 1'h1, 1'h0);
    edg(5'h02, 8'h82, 1'h0, 1'h1);
    for (int c = 0; c < 4; c++) edg(5'h0c, 8'((c << 4) | (c << 2)), c != 1, c != 0);
    low_speed_mode <= 1'h1;
    flt(4, 8'h00, 4, 1'h0);
    flt(4, 8'h00, 28, 1'h1);
    low_speed_mode <= 1'h0;
    trap(1'h0);
    trap(1'h1);
    chk(9'h104, 32'h20, 32'h20);
    wr(9'h104, 32'h20);
    @(negedge sys_clk);
    cmp({31'h0, address_trap_irq}, 32'h0);
    tally_and_finish;
  end
endmodule
